// [src/cfg_loader_pkg.sv]
// Functional notes
// (R1) Subsystem ID and vendor ID read 0000h until an EEPROM loads them; host writes only take effect after a load.
// (R2) After reset the loader probes the EEPROM and loads IDs plus two configuration bytes.
// (R3) A bad signature byte aborts the load and the fetched data is discarded.
// (R4) After loading, host software reads and writes EEPROM bytes through a device register.
// (R5) During transfers the data line changes only while the serial clock is low.
// (R6) Data changes while the clock is high happen only for start or stop framing.
// (R7) Loader reads use a dummy write of device address and byte address zero, then read.
// (R8) Loading starts at byte zero and proceeds with one sequential multi-byte read.
// (R9) Exactly seven bytes are fetched from the EEPROM.
// (R10) The power management capability reports version 01 in its three low bits.
// (R11) The capabilities word advertises D1 support through a read-only one.
// (R12) The power-event enable bit is host writable and resets to zero.
// (R13) The two low control/status bits hold the host-settable power state.
// (R14) The top control/status bit reports power-event status.
// (R15) Subsystem IDs are read-only zero without EEPROM, writable and loaded with one.
// (R16) An unacknowledged device address means no EEPROM; defaults stay, no retry.
package cfg_loader_pkg;
  localparam int          CLK_HZ        = 125000000;
  localparam int          ROM_BIT_HZ    = 6250000;
  localparam int          TICK_DIV      = CLK_HZ / (4 * ROM_BIT_HZ);
  localparam logic [6:0]  ROM_DEV_ADDR  = 7'h50;
  localparam logic [7:0]  ROM_SIGNATURE = 8'h55;
  localparam logic [2:0]  LOAD_LAST     = 3'h6;
  localparam logic [7:0]  OFS_SUBSYS    = 8'h2c;
  localparam logic [7:0]  OFS_EXP_ROM   = 8'h30;
  localparam logic [7:0]  OFS_RSVD_A    = 8'h34;
  localparam logic [7:0]  OFS_RSVD_B    = 8'h38;
  localparam logic [7:0]  OFS_LAT_GNT   = 8'h3c;
  localparam logic [7:0]  OFS_PM_CAP    = 8'h40;
  localparam logic [7:0]  OFS_PM_CSR    = 8'h44;
  localparam logic [7:0]  OFS_GEN_CFG   = 8'h48;
  localparam logic [7:0]  OFS_ROM_ACC   = 8'h4c;
  localparam logic [31:0] RSVD_A_VALUE  = 32'h01000000;
  localparam logic [15:0] LAT_GNT_VALUE = 16'h1804;
  localparam logic [7:0]  INT_PIN_VALUE = 8'h01;
  localparam logic [15:0] PM_CAP_VALUE  = 16'hfa01;
  localparam logic [15:0] PM_CAP_HEAD   = 16'h0001;
  localparam int          ACC_GO        = 31;
  localparam int          ACC_RD        = 16;
  localparam int          ACC_NACK      = 30;
  localparam int          ACC_LOADED    = 29;
  localparam int          PM_STAT_BIT   = 15;
  localparam int          PM_EN_BIT     = 8;
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} rom_op_t;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;
endpackage

// [src/cfg_rom_link.sv]
`timescale 1ns/100ps
`default_nettype none
module cfg_rom_link (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    go,
  input  wire cfg_loader_pkg::rom_op_t op,
  input  wire logic [7:0]              wdata,
  input  wire logic                    ack_bit,
  output logic                         busy,
  output logic                         done,
  output logic [7:0]                   rdata,
  output logic                         nack,
  output logic                         scl,
  output logic                         sda_oe,
  input  wire logic                    sda_in
);
  import cfg_loader_pkg::*;
  logic [8:0] tdiv;
  logic       tick;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [8:0] sh;
  rom_op_t    op_q;
  logic       sda_m;
  logic       sda_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m <= sda_in;
      sda_s <= sda_m;
    end
  end

  assign tick = (tdiv == 9'(TICK_DIV - 1));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tdiv <= '0;
    end else begin
      tdiv <= tick ? 9'h000 : tdiv + 9'h001;
    end
  end

  // Each bit spans four quarter-bit phases; bits change data only in phase 0 with the clock low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy   <= 1'b0;
      done   <= 1'b0;
      ph     <= 2'h0;
      bitn   <= 4'h0;
      sh     <= 9'h1ff;
      op_q   <= OP_START;
      scl    <= 1'b1;
      sda_oe <= 1'b0;
      rdata  <= 8'h00;
      nack   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy && go) begin
        busy <= 1'b1;
        op_q <= op;
        ph   <= 2'h0;
        bitn <= 4'h0;
        sh   <= (op == OP_READ) ? {8'hff, ack_bit} : {wdata, 1'b1};
      end else if (busy && tick) begin
        ph <= ph + 2'h1;
        unique case (op_q)
          OP_START: begin
            scl    <= (ph == 2'h1) || (ph == 2'h2); // see R6
            sda_oe <= ph[1];
          end
          OP_STOP: begin
            scl    <= (ph != 2'h0); // see R6
            sda_oe <= !ph[1];
          end
          OP_WRITE, OP_READ: begin
            scl <= (ph == 2'h1) || (ph == 2'h2);
            if (ph == 2'h0) begin
              sda_oe <= !sh[8]; // see R5
            end
            if (ph == 2'h2) begin
              sh <= {sh[7:0], sda_s};
            end
          end
        endcase
        if (ph == 2'h3) begin
          if (op_q == OP_START || op_q == OP_STOP || bitn == 4'h8) begin
            busy  <= 1'b0;
            done  <= 1'b1;
            rdata <= sh[8:1];
            nack  <= sh[0];
          end else begin
            bitn <= bitn + 4'h1;
          end
        end
      end
    end
  end

  property p_data_low_clock;
    @(posedge clk) disable iff (!rst_b)
      busy && (op_q == OP_WRITE || op_q == OP_READ) && $changed(sda_oe) |-> !scl && !$past(scl);
  endproperty
  a_data_low_clock: assert property (p_data_low_clock) else $error("data moved with clock high"); // see R5

  property p_framing_only;
    @(posedge clk) disable iff (!rst_b)
      scl && $past(scl) && $changed(sda_oe) |-> (op_q == OP_START || op_q == OP_STOP);
  endproperty
  a_framing_only: assert property (p_framing_only) else $error("unframed data edge under high clock"); // see R6
endmodule
`default_nettype wire

// [src/pci_config_eeprom_loader.sv]
`timescale 1ns/100ps
`default_nettype none
module pci_config_eeprom_loader (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     cfg_valid,
  input  wire cfg_loader_pkg::cfg_req_t cfg_req,
  output logic                          cfg_ack,
  output logic [31:0]                   cfg_rdata,
  input  wire logic                     power_event_in,
  output logic                          power_event_request,
  output logic [1:0]                    power_state,
  output logic                          ext_cfg_rom_present,
  output logic [15:0]                   general_config,
  output logic                          cfg_rom_clock_line,
  output logic                          cfg_rom_data_line_oe,
  output logic                          cfg_rom_data_line_out,
  input  wire logic                     cfg_rom_data_line_in
);
  import cfg_loader_pkg::*;

  typedef enum logic [3:0] {
    ST_BOOT, ST_START, ST_DEVW, ST_ADDR, ST_WDATA,
    ST_RSTART, ST_DEVR, ST_READ, ST_STOP, ST_IDLE
  } state_t;

  state_t      state;
  logic        load_mode;
  logic        load_ok;
  logic [2:0]  cnt;
  logic [7:0]  rom_buf [7];
  logic        host_wr;
  logic [7:0]  host_addr;
  logic [7:0]  host_data;
  logic [7:0]  host_rdata;
  logic        host_nack;
  logic        waiting;
  logic        eng_go;
  rom_op_t     eng_op;
  logic [7:0]  eng_wdata;
  logic        eng_ack;
  logic        eng_busy;
  logic        eng_done;
  logic [7:0]  eng_rdata;
  logic        eng_nack;
  logic        commit;
  logic        host_go;
  logic [15:0] subsys_vid;
  logic [15:0] subsys_id;
  logic [7:0]  int_line;
  logic        power_event_enable;
  logic        pme_status;
  logic [31:0] next_rdata;
  logic        wr_hit;

  cfg_rom_link i_cfg_rom_link (
    .clk     (clk),
    .rst_b   (rst_b),
    .go      (eng_go),
    .op      (eng_op),
    .wdata   (eng_wdata),
    .ack_bit (eng_ack),
    .busy    (eng_busy),
    .done    (eng_done),
    .rdata   (eng_rdata),
    .nack    (eng_nack),
    .scl     (cfg_rom_clock_line),
    .sda_oe  (cfg_rom_data_line_oe),
    .sda_in  (cfg_rom_data_line_in)
  );

  assign cfg_rom_data_line_out = 1'b0;
  assign wr_hit  = cfg_valid && cfg_req.wr;
  assign host_go = wr_hit && (cfg_req.addr == OFS_ROM_ACC) && cfg_req.wdata[ACC_GO] && (state == ST_IDLE);
  assign commit  = eng_done && (state == ST_STOP) && load_mode && load_ok;

  always_comb begin
    eng_op    = OP_START;
    eng_wdata = 8'h00;
    unique case (state)
      ST_DEVW: begin
        eng_op    = OP_WRITE;
        eng_wdata = {ROM_DEV_ADDR, 1'b0};
      end
      ST_ADDR: begin
        eng_op    = OP_WRITE;
        eng_wdata = load_mode ? 8'h00 : host_addr; // see R7
      end
      ST_WDATA: begin
        eng_op    = OP_WRITE;
        eng_wdata = host_data;
      end
      ST_DEVR: begin
        eng_op    = OP_WRITE;
        eng_wdata = {ROM_DEV_ADDR, 1'b1};
      end
      ST_READ:  eng_op = OP_READ;
      ST_STOP:  eng_op = OP_STOP;
      ST_BOOT, ST_START, ST_RSTART, ST_IDLE: eng_op = OP_START;
    endcase
  end

  // The last loader byte is answered with no-acknowledge so the EEPROM frees the line.
  assign eng_ack = load_mode ? (cnt == LOAD_LAST) : 1'b1; // see R9
  assign eng_go  = (state != ST_BOOT) && (state != ST_IDLE) && !eng_busy && !waiting;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waiting <= 1'b0;
    end else if (eng_go) begin
      waiting <= 1'b1;
    end else if (eng_done) begin
      waiting <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= ST_BOOT;
      load_mode <= 1'b1;
      load_ok   <= 1'b0;
      cnt       <= 3'h0;
    end else begin
      unique case (state)
        ST_BOOT: state <= ST_START; // see R2
        ST_IDLE: if (host_go) state <= ST_START; // see R4
        default: if (eng_done) begin
          unique case (state)
            ST_START:  state <= ST_DEVW;
            ST_DEVW:   state <= eng_nack ? ST_STOP : ST_ADDR; // see R16
            ST_ADDR:   state <= (!load_mode && host_wr) ? ST_WDATA : ST_RSTART;
            ST_WDATA:  state <= ST_STOP;
            ST_RSTART: state <= ST_DEVR;
            ST_DEVR:   state <= eng_nack ? ST_STOP : ST_READ;
            ST_READ: begin
              if (!load_mode) begin
                state <= ST_STOP;
              end else if (cnt == 3'h0 && eng_rdata != ROM_SIGNATURE) begin
                state <= ST_STOP; // see R3
              end else if (cnt == LOAD_LAST) begin
                state   <= ST_STOP; // see R9
                load_ok <= 1'b1;
              end else begin
                cnt <= cnt + 3'h1; // see R8
              end
            end
            default: begin
              state     <= ST_IDLE;
              load_mode <= 1'b0;
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (eng_done && state == ST_READ && load_mode) begin
      rom_buf[cnt] <= eng_rdata; // see R8
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_wr    <= 1'b0;
      host_addr  <= 8'h00;
      host_data  <= 8'h00;
      host_rdata <= 8'h00;
      host_nack  <= 1'b0;
    end else begin
      if (host_go) begin
        host_wr   <= !cfg_req.wdata[ACC_RD];
        host_addr <= cfg_req.wdata[15:8];
        host_data <= cfg_req.wdata[7:0];
        host_nack <= 1'b0;
      end
      if (eng_done && !load_mode && eng_nack && (state == ST_DEVW || state == ST_DEVR)) begin
        host_nack <= 1'b1;
      end
      if (eng_done && !load_mode && state == ST_READ) begin
        host_rdata <= eng_rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_cfg_rom_present <= 1'b0;
      subsys_vid          <= 16'h0000;
      subsys_id           <= 16'h0000;
      general_config      <= 16'h0000;
    end else if (commit) begin
      ext_cfg_rom_present <= 1'b1;
      general_config      <= {rom_buf[2], rom_buf[1]};
      subsys_vid          <= {rom_buf[4], rom_buf[3]};
      subsys_id           <= {rom_buf[6], rom_buf[5]};
    end else if (wr_hit && cfg_req.addr == OFS_SUBSYS && ext_cfg_rom_present) begin
      if (cfg_req.be[0]) subsys_vid[7:0]  <= cfg_req.wdata[7:0]; // see R15
      if (cfg_req.be[1]) subsys_vid[15:8] <= cfg_req.wdata[15:8];
      if (cfg_req.be[2]) subsys_id[7:0]   <= cfg_req.wdata[23:16];
      if (cfg_req.be[3]) subsys_id[15:8]  <= cfg_req.wdata[31:24];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_line    <= 8'h00;
      power_event_enable      <= 1'b0;
      power_state <= 2'h0;
    end else if (wr_hit) begin
      if (cfg_req.addr == OFS_LAT_GNT && cfg_req.be[0]) int_line <= cfg_req.wdata[7:0];
      if (cfg_req.addr == OFS_PM_CSR && cfg_req.be[1]) power_event_enable <= cfg_req.wdata[PM_EN_BIT]; // see R12
      if (cfg_req.addr == OFS_PM_CSR && cfg_req.be[0]) power_state <= cfg_req.wdata[1:0]; // see R13
    end
  end

  // A new power event in the cycle of a write-one clear keeps the status set.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pme_status <= 1'b0;
    end else if (power_event_in) begin
      pme_status <= 1'b1; // see R14
    end else if (wr_hit && cfg_req.addr == OFS_PM_CSR && cfg_req.be[1] && cfg_req.wdata[PM_STAT_BIT]) begin
      pme_status <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_event_request <= 1'b0;
    end else begin
      power_event_request <= pme_status && power_event_enable;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    unique case (cfg_req.addr)
      OFS_SUBSYS:  next_rdata = {subsys_id, subsys_vid}; // see R1
      OFS_EXP_ROM: next_rdata = 32'h00000000;
      OFS_RSVD_A:  next_rdata = RSVD_A_VALUE;
      OFS_RSVD_B:  next_rdata = 32'h00000000;
      OFS_LAT_GNT: next_rdata = {LAT_GNT_VALUE, INT_PIN_VALUE, int_line};
      OFS_PM_CAP:  next_rdata = {PM_CAP_VALUE, PM_CAP_HEAD}; // see R10 R11
      OFS_PM_CSR:  next_rdata = {16'h0000, pme_status, 6'h00, power_event_enable, 6'h00, power_state};
      OFS_GEN_CFG: next_rdata = {16'h0000, general_config};
      OFS_ROM_ACC: next_rdata = {(state != ST_IDLE), host_nack, !load_mode, 21'h000000, host_rdata};
      default:     next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= 32'h00000000;
    end else begin
      cfg_ack   <= cfg_valid;
      cfg_rdata <= (cfg_valid && !cfg_req.wr) ? next_rdata : 32'h00000000;
    end
  end

  property p_ids_zero;
    @(posedge clk) disable iff (!rst_b)
      cfg_valid && !cfg_req.wr && cfg_req.addr == OFS_SUBSYS && !ext_cfg_rom_present |=> cfg_rdata == 32'h0;
  endproperty
  a_ids_zero: assert property (p_ids_zero) else $error("subsystem ids nonzero without eeprom"); // see R1

  property p_boot_probe;
    @(posedge clk) disable iff (!rst_b)
      state == ST_BOOT |=> state == ST_START && eng_go;
  endproperty
  a_boot_probe: assert property (p_boot_probe) else $error("probe did not start after reset"); // see R2

  property p_bad_sig;
    @(posedge clk) disable iff (!rst_b)
      eng_done && state == ST_READ && load_mode && cnt == 3'h0 && eng_rdata != ROM_SIGNATURE
      |=> state == ST_STOP && !load_ok;
  endproperty
  a_bad_sig: assert property (p_bad_sig) else $error("bad signature not aborted"); // see R3

  property p_host_go;
    @(posedge clk) disable iff (!rst_b)
      host_go |=> state == ST_START && !load_mode;
  endproperty
  a_host_go: assert property (p_host_go) else $error("host eeprom access not started"); // see R4

  property p_addr_zero;
    @(posedge clk) disable iff (!rst_b)
      eng_go && load_mode && state == ST_ADDR |-> eng_wdata == 8'h00 && eng_op == OP_WRITE;
  endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("load byte address not zero"); // see R7

  property p_seq_read;
    @(posedge clk) disable iff (!rst_b)
      eng_done && state == ST_READ && load_mode && cnt != LOAD_LAST && load_ok == 1'b0 && !(cnt == 3'h0
      && eng_rdata != ROM_SIGNATURE) |=> state == ST_READ && cnt == $past(cnt) + 3'h1;
  endproperty
  a_seq_read: assert property (p_seq_read) else $error("sequential read did not advance"); // see R8

  property p_seven;
    @(posedge clk) disable iff (!rst_b)
      eng_go && load_mode && state == ST_READ |-> eng_ack == (cnt == LOAD_LAST);
  endproperty
  a_seven: assert property (p_seven) else $error("wrong last byte acknowledge"); // see R9

  property p_pm_cap;
    @(posedge clk) disable iff (!rst_b)
      cfg_valid && !cfg_req.wr && cfg_req.addr == OFS_PM_CAP |=> cfg_rdata[18:16] == 3'h1 && cfg_rdata[25];
  endproperty
  a_pm_cap: assert property (p_pm_cap) else $error("pm capability version or d1 wrong"); // see R10 R11

  property p_power_event_enable;
    @(posedge clk) disable iff (!rst_b)
      wr_hit && cfg_req.addr == OFS_PM_CSR && cfg_req.be[1] |=> power_event_enable == $past(cfg_req.wdata[PM_EN_BIT]);
  endproperty
  a_power_event_enable: assert property (p_power_event_enable) else $error("power event enable not written"); // see R12

  property p_pstate;
    @(posedge clk) disable iff (!rst_b)
      wr_hit && cfg_req.addr == OFS_PM_CSR && cfg_req.be[0] |=> ##1 power_state == $past(cfg_req.wdata[1:0], 2);
  endproperty
  a_pstate: assert property (p_pstate) else $error("power state not written"); // see R13

  property p_pme_stat;
    @(posedge clk) disable iff (!rst_b)
      power_event_in |=> pme_status ##1 (power_event_request == $past(power_event_enable));
  endproperty
  a_pme_stat: assert property (p_pme_stat) else $error("power event status lost"); // see R14

  property p_absent;
    @(posedge clk) disable iff (!rst_b)
      eng_done && load_mode && state == ST_DEVW && eng_nack |=> state == ST_STOP && !ext_cfg_rom_present;
  endproperty
  a_absent: assert property (p_absent) else $error("absent eeprom not handled"); // see R16

  property p_commit;
    @(posedge clk) disable iff (!rst_b)
      commit |=> ext_cfg_rom_present && subsys_id == {rom_buf[6], rom_buf[5]};
  endproperty
  a_commit: assert property (p_commit) else $error("loaded ids not committed"); // see R15

  c_loaded: cover property (@(posedge clk) disable iff (!rst_b) commit);
  c_absent: cover property (@(posedge clk) disable iff (!rst_b) eng_done && load_mode && eng_nack);
  c_host_rd: cover property (@(posedge clk) disable iff (!rst_b) eng_done && !load_mode && state == ST_READ);
  c_host_wr: cover property (@(posedge clk) disable iff (!rst_b) eng_done && state == ST_WDATA);
endmodule
`default_nettype wire

// [tb/cfg_rom_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cfg_rom_model
  import cfg_loader_pkg::*;
(
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic present,
  output logic      sda_pull
);
  logic [7:0] mem [0:7];
  logic [7:0] sh = 8'h00;
  logic [2:0] ptr = 3'h0;
  logic [7:0] first_addr = 8'hff;
  int         bitn = 0;
  int         phase = 4;
  int         bytes_read = 0;
  int         num_starts = 0;
  initial sda_pull = 1'b0;
  // Framing is only recognised while the clock is high.
  always @(sda) begin
    if (scl === 1'b1 && sda === 1'b0) begin
      bitn = 0;
      phase = 0;
      num_starts++;
    end else if (scl === 1'b1) begin
      phase = 4;
      sda_pull = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda};
      bitn++;
    end else begin
      bitn = 0;
      if (phase == 3 && sda === 1'b1) phase = 4;
    end
  end
  // The model drives the data line after a clock fall and releases it on a stop.
  always @(negedge scl) begin
    if (bitn == 8 && phase < 3) begin
      case (phase)
        0: phase = (present && sh[7:1] == ROM_DEV_ADDR) ? (sh[0] ? 3 : 1) : 4;
        1: begin
          ptr = sh[2:0];
          if (first_addr == 8'hff) first_addr = sh;
          phase = 2;
        end
        default: begin
          mem[ptr] = sh;
          ptr++;
        end
      endcase
      sda_pull = (phase != 4);
    end else if (phase == 3 && bitn < 8) begin
      sda_pull = ~mem[ptr][7-bitn];
    end else if (phase == 3) begin
      sda_pull = 1'b0;
      ptr++;
      bytes_read++;
    end else begin
      sda_pull = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [tb/test_pci_config_eeprom_loader.sv]
`timescale 1ns/100ps
`default_nettype none
module test_pci_config_eeprom_loader;
  import cfg_loader_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cfg_valid = 1'b0;
  cfg_req_t    cfg_req = '0;
  logic        cfg_ack;
  logic [31:0] cfg_rdata;
  logic        power_event_in = 1'b0;
  logic        power_event_request;
  logic [1:0]  power_state;
  logic        ext_cfg_rom_present;
  logic [15:0] general_config;
  logic        scl;
  logic        sda_oe;
  logic        sda_out;
  logic        sda_pull;
  logic        rom_present = 1'b0;
  wire         sda;
  int          errors = 0;
  int          num_checks = 0;
  logic [31:0] v;
  // Open-drain line with a pull-up.
  assign sda = ((sda_oe && !sda_out) || sda_pull) ? 1'b0 : 1'b1;
  pci_config_eeprom_loader i_pci_config_eeprom_loader (
    .clk(clk), .rst_b(rst_b), .cfg_valid(cfg_valid), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .power_event_in(power_event_in), .power_event_request(power_event_request),
    .power_state(power_state), .ext_cfg_rom_present(ext_cfg_rom_present), .general_config(general_config),
    .cfg_rom_clock_line(scl), .cfg_rom_data_line_oe(sda_oe), .cfg_rom_data_line_out(sda_out),
    .cfg_rom_data_line_in(sda)
  );
  cfg_rom_model i_cfg_rom_model (.scl(scl), .sda(sda), .present(rom_present), .sda_pull(sda_pull));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    cfg_valid <= 1'b1;
    cfg_req   <= '{wr: w, addr: a, be: be, wdata: wd};
    @(posedge clk);
    cfg_valid <= 1'b0;
    #1;
    chk("cfg_ack", cfg_ack, 32'h1);
    rd = cfg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    cfg(1'b1, a, be, wd, v);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    cfg(1'b0, a, 4'hf, 32'h0, v);
    chk(name, v, exp);
  endtask
  task automatic do_reset(input logic pres, input logic [7:0] sig);
    @(posedge clk);
    rst_b <= 1'b0;
    rom_present <= pres;
    i_cfg_rom_model.mem[0] = sig;
    i_cfg_rom_model.bytes_read = 0;
    i_cfg_rom_model.num_starts = 0;
    i_cfg_rom_model.first_addr = 8'hff;
    i_cfg_rom_model.phase = 4;
    i_cfg_rom_model.sda_pull = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic wait_loaded();
    for (int i = 0; i < 1000; i++) begin
      repeat (200) @(posedge clk);
      cfg(1'b0, OFS_ROM_ACC, 4'hf, 32'h0, v);
      if (v[ACC_LOADED] === 1'b1) break;
    end
    chk("load_done", {31'h0, v[ACC_LOADED]}, 32'h1);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 1000; i++) begin
      repeat (200) @(posedge clk);
      cfg(1'b0, OFS_ROM_ACC, 4'hf, 32'h0, v);
      if (v[ACC_GO] === 1'b0) break;
    end
    chk("rom_idle", {31'h0, v[ACC_GO]}, 32'h0);
  endtask
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
  initial begin
    i_cfg_rom_model.mem[1] = 8'h34;
    i_cfg_rom_model.mem[2] = 8'h12;
    i_cfg_rom_model.mem[3] = 8'h78;
    i_cfg_rom_model.mem[4] = 8'h56;
    i_cfg_rom_model.mem[5] = 8'hcd;
    i_cfg_rom_model.mem[6] = 8'hab;
    i_cfg_rom_model.mem[7] = 8'h00;
    do_reset(1'b0, 8'h55);
    rd_chk(OFS_SUBSYS, 32'h0, "subsys");
    rd_chk(OFS_EXP_ROM, 32'h0, "exp_rom");
    rd_chk(OFS_RSVD_A, 32'h01000000, "rsvd_a");
    rd_chk(OFS_RSVD_B, 32'h0, "rsvd_b");
    rd_chk(OFS_PM_CSR, 32'h0, "pm_csr_reset");
    wr(OFS_SUBSYS, 4'hf, 32'h1234_5678);
    wr(OFS_EXP_ROM, 4'hf, 32'hffff_ffff);
    wr(OFS_PM_CAP, 4'hf, 32'hffff_ffff);
    rd_chk(OFS_SUBSYS, 32'h0, "subsys_ro");
    rd_chk(OFS_EXP_ROM, 32'h0, "exp_rom_ro");
    rd_chk(OFS_PM_CAP, 32'hfa01_0001, "pm_cap");
    wr(OFS_LAT_GNT, 4'h1, 32'hffff_ff0b);
    rd_chk(OFS_LAT_GNT, 32'h1804_010b, "lat_gnt");
    wr(OFS_PM_CSR, 4'hf, 32'hffff_7fff);
    rd_chk(OFS_PM_CSR, 32'h0000_0103, "pm_csr_rw");
    chk("power_state", {30'h0, power_state}, 32'h3);
    @(posedge clk);
    power_event_in <= 1'b1;
    @(posedge clk);
    power_event_in <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(OFS_PM_CSR, 32'h0000_8103, "pm_status");
    chk("event_req", {31'h0, power_event_request}, 32'h1);
    wr(OFS_PM_CSR, 4'hf, 32'hffff_ffff);
    rd_chk(OFS_PM_CSR, 32'h0000_0103, "pm_w1c");
    repeat (2) @(posedge clk);
    chk("event_req_clr", {31'h0, power_event_request}, 32'h0);
    rd_chk(8'h80, 32'h0, "unmapped");
    wait_loaded();
    chk("absent", {31'h0, ext_cfg_rom_present}, 32'h0);
    chk("no_retry", i_cfg_rom_model.num_starts, 32'h1);
    rd_chk(OFS_SUBSYS, 32'h0, "subsys_absent");
    do_reset(1'b1, 8'haa);
    rd_chk(OFS_PM_CSR, 32'h0, "pm_csr_rereset");
    wait_loaded();
    chk("bad_sig", {31'h0, ext_cfg_rom_present}, 32'h0);
    chk("bad_sig_gc", {16'h0, general_config}, 32'h0);
    rd_chk(OFS_SUBSYS, 32'h0, "bad_sig_ids");
    do_reset(1'b1, 8'h55);
    wait_loaded();
    chk("present", {31'h0, ext_cfg_rom_present}, 32'h1);
    chk("gen_cfg", {16'h0, general_config}, 32'h1234);
    rd_chk(OFS_SUBSYS, 32'habcd_5678, "ids_loaded");
    chk("bytes_read", i_cfg_rom_model.bytes_read, 32'h7);
    chk("starts", i_cfg_rom_model.num_starts, 32'h2);
    chk("first_addr", {24'h0, i_cfg_rom_model.first_addr}, 32'h0);
    wr(OFS_SUBSYS, 4'h3, 32'h0000_1111);
    rd_chk(OFS_SUBSYS, 32'habcd_1111, "ids_host");
    wr(OFS_ROM_ACC, 4'hf, 32'h8000_075a);
    wait_idle();
    chk("host_wr_mem", {24'h0, i_cfg_rom_model.mem[7]}, 32'h5a);
    wr(OFS_ROM_ACC, 4'hf, 32'h8001_0300);
    wait_idle();
    rd_chk(OFS_ROM_ACC, 32'h2000_0078, "host_rd");
    wr(OFS_ROM_ACC, 4'hf, 32'h8001_0700);
    wait_idle();
    rd_chk(OFS_ROM_ACC, 32'h2000_005a, "host_rd_back");
    report_and_stop();
  end
endmodule
`default_nettype wire
